// file: src/eeac_array.sv
// Byte-wide storage array of the data EEPROM, one write port and one read port.
`timescale 1ns/100ps
`include "eeac_map.svh"
module eeac_array #(
  parameter int DEPTH = `EEAC_DEPTH,
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
  } eeac_array_s;

  eeac_array_s s;
  eeac_array_s next_s;

  // Cells are nonvolatile, so no reset touches them.
  always_comb begin
    next_s = s;
    if (wr_en_in) begin
      next_s.cells[wr_addr_in] = wr_data_in;
    end
  end

  // The array keeps its contents through every reset.
  always_ff @(posedge clk_sys_in) begin
    s <= next_s;
  end

  // Asynchronous read; the controller registers the byte itself.
  assign rd_data_out = s.cells[rd_addr_in];

endmodule

// file: src/eeac_map.svh
// Register map, field positions, reset values and timing figures of the EEPROM access block.
`ifndef EEAC_MAP_SVH
`define EEAC_MAP_SVH

// APB address width; a register index sits in paddr[13:2].
`define EEAC_APB_ADDR_W 14
`define EEAC_IDX_W 12

// Register indices; the byte address is four times the index.
`define EEAC_IDX_CTRL 12'hFA6
`define EEAC_IDX_UNLOCK 12'hFA7
`define EEAC_IDX_DATA 12'hFA8
`define EEAC_IDX_ADDR_LO 12'hFA9
`define EEAC_IDX_ADDR_HI 12'hFAA
`define EEAC_IDX_FLAG 12'hFAB

// Control register bit positions.
`define EEAC_CTRL_PROG_SEL 7
`define EEAC_CTRL_CFG_SEL 6
`define EEAC_CTRL_ROW_ERASE 4
`define EEAC_CTRL_ABORT 3
`define EEAC_CTRL_STORE_EN 2
`define EEAC_CTRL_STORE_GO 1
`define EEAC_CTRL_FETCH_GO 0

// Flag register bit position of the write-done flag.
`define EEAC_FLAG_DONE 4

// Unlock keys and the value of an erased cell.
`define EEAC_KEY_FIRST 8'h55
`define EEAC_KEY_SECOND 8'hAA
`define EEAC_ERASED 8'hFF

// Array geometry.
`define EEAC_DEPTH 1024
`define EEAC_ADDR_W 10
`define EEAC_ADDR_HI_W 2

// All state resets to zero.
`define EEAC_RESET_STATE '0

// Timing: clock period and default self-timed write duration.
`define EEAC_CLK_PERIOD_NS 50
`define EEAC_WRITE_TIME_NS 4000000
`define EEAC_TIMER_W 24

`endif

// file: src/eeac_pkg.sv
// Types shared by the EEPROM access block.
`include "eeac_map.svh"
package eeac_pkg;

  // Register selected by an APB address.
  typedef enum logic [2:0] {
    EEAC_REG_NONE = 3'h0,
    EEAC_REG_CTRL = 3'h1,
    EEAC_REG_UNLOCK = 3'h2,
    EEAC_REG_DATA = 3'h3,
    EEAC_REG_ADDR_LO = 3'h4,
    EEAC_REG_ADDR_HI = 3'h5,
    EEAC_REG_FLAG = 3'h6
  } eeac_reg_e;

  // Unlock sequence progress, Gray coded.
  typedef enum logic [1:0] {
    EEAC_UNL_IDLE = 2'h0,
    EEAC_UNL_FIRST = 2'h1,
    EEAC_UNL_ARMED = 2'h3
  } eeac_unlock_e;

  // Self-timed write phases, Gray coded.
  typedef enum logic [1:0] {
    EEAC_WR_IDLE = 2'h0,
    EEAC_WR_ERASE = 2'h1,
    EEAC_WR_PROG = 2'h3
  } eeac_wstate_e;

  // Complete state of the access controller.
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr_lo;
    logic [`EEAC_ADDR_HI_W-1:0] addr_hi;
    logic prog_sel;
    logic cfg_sel;
    logic row_erase;
    logic abort;
    logic store_en;
    logic store_go;
    logic fetch_go;
    logic done;
    logic row_erase_act;
    eeac_unlock_e unlock;
    eeac_wstate_e wstate;
    logic [`EEAC_TIMER_W-1:0] timer;
    logic master_clear_reset_s1;
    logic master_clear_reset_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } eeac_state_s;

endpackage

// file: src/eeac_top.sv
// APB-reached access controller for the 1024-byte data EEPROM.
//
// Summary of operation
// - 1024 bytes, addresses zero to 3FF.
// - Two high bits from high register.
// - Write erases then programs, internally timed.
// - Unlock register stores nothing, reads zero.
// - Go bits set-only; hardware clears them.
// - Writes need store enable; cleared at reset.
// - Warm reset during write sets abort flag.
// - Abort keeps program and row-erase selects.
// - Reset zeroes data and address registers.
// - Done flag set by hardware, cleared by software.
// - Bit 7 selects program flash.
// - Bit 6 selects configuration space.
// - Row erase bit, with bit 7 set, erases row, then clears.
// - Fetch completes in one cycle; blocked by bit 7.
// - Fetched byte readable on next cycle.
// - Data holds until next fetch or write.
// - Control bit 5 reads zero.
// - Keys 55 then AA then store go.
// - Store go needs store enable already set.
// - Busy write locks control, address, data.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "eeac_map.svh"
module eeac_top #(
  parameter int unsigned WRITE_CYCLES = `EEAC_WRITE_TIME_NS / `EEAC_CLK_PERIOD_NS
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic master_clear_reset_in,
  input wire logic watchdog_timer_reset_in,
  input wire logic [`EEAC_APB_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  output logic eeprom_done_flag_out,
  output logic write_busy_out,
  output logic flash_row_erase_out
);

  localparam int TW = `EEAC_TIMER_W;
  localparam int unsigned ERASE_CYCLES = WRITE_CYCLES / 2;
  localparam int unsigned PROG_CYCLES = WRITE_CYCLES - ERASE_CYCLES;
  localparam logic [TW-1:0] ERASE_LOAD = TW'(ERASE_CYCLES - 1);
  localparam logic [TW-1:0] PROG_LOAD = TW'(PROG_CYCLES - 1);

  eeac_pkg::eeac_state_s s;
  eeac_pkg::eeac_state_s next_s;
  eeac_pkg::eeac_reg_e sel;
  logic warm;
  logic setup;
  logic acc_wr;
  logic [7:0] wbyte;
  logic arr_we;
  logic [7:0] arr_wdata;
  logic [7:0] arr_rdata;
  logic eeprom_target;

  // Maps an APB byte address onto a register; unaligned addresses match nothing.
  function automatic eeac_pkg::eeac_reg_e decode(input logic [`EEAC_APB_ADDR_W-1:0] addr);
    logic [`EEAC_IDX_W-1:0] idx;
    idx = addr[`EEAC_APB_ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      return eeac_pkg::EEAC_REG_NONE;
    end
    unique case (idx)
      `EEAC_IDX_CTRL: return eeac_pkg::EEAC_REG_CTRL;
      `EEAC_IDX_UNLOCK: return eeac_pkg::EEAC_REG_UNLOCK;
      `EEAC_IDX_DATA: return eeac_pkg::EEAC_REG_DATA;
      `EEAC_IDX_ADDR_LO: return eeac_pkg::EEAC_REG_ADDR_LO;
      `EEAC_IDX_ADDR_HI: return eeac_pkg::EEAC_REG_ADDR_HI;
      `EEAC_IDX_FLAG: return eeac_pkg::EEAC_REG_FLAG;
      default: return eeac_pkg::EEAC_REG_NONE;
    endcase
  endfunction

  // Read view of a register; unimplemented bits come back as zero.
  function automatic logic [7:0] read_byte(input eeac_pkg::eeac_state_s st,
                                           input eeac_pkg::eeac_reg_e rs);
    logic [7:0] b;
    b = 8'h00;
    unique case (rs)
      eeac_pkg::EEAC_REG_CTRL: begin
        b[`EEAC_CTRL_PROG_SEL] = st.prog_sel;
        b[`EEAC_CTRL_CFG_SEL] = st.cfg_sel;
        b[`EEAC_CTRL_ROW_ERASE] = st.row_erase;
        b[`EEAC_CTRL_ABORT] = st.abort;
        b[`EEAC_CTRL_STORE_EN] = st.store_en;
        b[`EEAC_CTRL_STORE_GO] = st.store_go;
        b[`EEAC_CTRL_FETCH_GO] = st.fetch_go;
      end
      eeac_pkg::EEAC_REG_DATA: b = st.data;
      eeac_pkg::EEAC_REG_ADDR_LO: b = st.addr_lo;
      eeac_pkg::EEAC_REG_ADDR_HI: b[`EEAC_ADDR_HI_W-1:0] = st.addr_hi;
      eeac_pkg::EEAC_REG_FLAG: b[`EEAC_FLAG_DONE] = st.done;
      eeac_pkg::EEAC_REG_UNLOCK: b = 8'h00;
      eeac_pkg::EEAC_REG_NONE: b = 8'h00;
    endcase
    return b;
  endfunction

  // Bus qualifiers; a write lands only at the edge that closes its access phase.
  assign sel = decode(paddr_in);
  assign setup = psel_in & ~penable_in;
  assign acc_wr = psel_in & penable_in & s.pready & pwrite_in & pstrb_in[0];
  assign wbyte = pwdata_in[7:0];
  assign warm = s.master_clear_reset_s2 | watchdog_timer_reset_in;
  assign eeprom_target = ~s.prog_sel & ~s.cfg_sel;

  // Storage array, addressed by the ten-bit pair.
  eeac_array #(
    .DEPTH(`EEAC_DEPTH),
    .WIDTH(8)
  ) u_eeac_array (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(arr_we),
    .wr_addr_in({s.addr_hi, s.addr_lo}),
    .wr_data_in(arr_wdata),
    .rd_addr_in({s.addr_hi, s.addr_lo}),
    .rd_data_out(arr_rdata)
  );

  // Next-state logic: bus, unlock, fetch, self-timed write, then warm reset last so it wins.
  always_comb begin
    next_s = s;
    arr_we = 1'b0;
    arr_wdata = s.data;
    next_s.master_clear_reset_s1 = master_clear_reset_in;
    next_s.master_clear_reset_s2 = s.master_clear_reset_s1;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    // The answer is prepared in the setup cycle so that every bus output is a flop.
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.pslverr = (sel == eeac_pkg::EEAC_REG_NONE);
      next_s.prdata = pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_byte(s, sel)};
    end
    // Register writes.
    if (acc_wr && !warm) begin
      // Any write to a mapped register other than the expected key drops the unlock progress.
      next_s.unlock = eeac_pkg::EEAC_UNL_IDLE;
      unique case (sel)
        eeac_pkg::EEAC_REG_UNLOCK: begin
          if (wbyte == `EEAC_KEY_FIRST) begin
            next_s.unlock = eeac_pkg::EEAC_UNL_FIRST;
          end else if (wbyte == `EEAC_KEY_SECOND && s.unlock == eeac_pkg::EEAC_UNL_FIRST) begin
            next_s.unlock = eeac_pkg::EEAC_UNL_ARMED;
          end
        end
        eeac_pkg::EEAC_REG_CTRL: begin
          if (!s.store_go) begin
            next_s.prog_sel = wbyte[`EEAC_CTRL_PROG_SEL];
            next_s.cfg_sel = wbyte[`EEAC_CTRL_CFG_SEL];
            next_s.row_erase = wbyte[`EEAC_CTRL_ROW_ERASE];
            next_s.abort = wbyte[`EEAC_CTRL_ABORT];
            next_s.store_en = wbyte[`EEAC_CTRL_STORE_EN];
            // Go bits only ever set here; store go needs the previous enable already on.
            if (wbyte[`EEAC_CTRL_STORE_GO] && s.store_en &&
                s.unlock == eeac_pkg::EEAC_UNL_ARMED) begin
              next_s.store_go = 1'b1;
              next_s.wstate = eeac_pkg::EEAC_WR_ERASE;
              next_s.timer = ERASE_LOAD;
              next_s.row_erase_act = wbyte[`EEAC_CTRL_PROG_SEL] &
                                     wbyte[`EEAC_CTRL_ROW_ERASE];
            end
            if (wbyte[`EEAC_CTRL_FETCH_GO] && !s.prog_sel) begin
              next_s.fetch_go = 1'b1;
            end
          end
        end
        eeac_pkg::EEAC_REG_DATA: begin
          if (!s.store_go) begin
            next_s.data = wbyte;
          end
        end
        eeac_pkg::EEAC_REG_ADDR_LO: begin
          if (!s.store_go) begin
            next_s.addr_lo = wbyte;
          end
        end
        eeac_pkg::EEAC_REG_ADDR_HI: begin
          if (!s.store_go) begin
            next_s.addr_hi = wbyte[`EEAC_ADDR_HI_W-1:0];
          end
        end
        eeac_pkg::EEAC_REG_FLAG: next_s.done = wbyte[`EEAC_FLAG_DONE];
        eeac_pkg::EEAC_REG_NONE: next_s.unlock = s.unlock;
      endcase
    end
    // A fetch takes exactly one cycle; configuration space has no cells here and reads zero.
    if (s.fetch_go) begin
      next_s.fetch_go = 1'b0;
      next_s.data = s.cfg_sel ? 8'h00 : arr_rdata;
    end
    // Self-timed write: erase phase, then program phase; software cannot stop it.
    unique case (s.wstate)
      eeac_pkg::EEAC_WR_IDLE: begin
      end
      eeac_pkg::EEAC_WR_ERASE: begin
        if (s.timer == '0) begin
          next_s.wstate = eeac_pkg::EEAC_WR_PROG;
          next_s.timer = PROG_LOAD;
          arr_we = eeprom_target;
          arr_wdata = `EEAC_ERASED;
        end else begin
          next_s.timer = s.timer - 1'b1;
        end
      end
      eeac_pkg::EEAC_WR_PROG: begin
        if (s.timer == '0) begin
          next_s.wstate = eeac_pkg::EEAC_WR_IDLE;
          next_s.store_go = 1'b0;
          next_s.done = 1'b1;
          next_s.row_erase_act = 1'b0;
          arr_we = eeprom_target;
          arr_wdata = s.data;
          if (s.row_erase_act) begin
            next_s.row_erase = 1'b0;
          end
        end else begin
          next_s.timer = s.timer - 1'b1;
        end
      end
      default: next_s.wstate = eeac_pkg::EEAC_WR_IDLE;
    endcase
    // Warm reset: cut any write short and flag it, but keep the selects for tracing.
    if (warm) begin
      next_s.abort = s.abort | s.store_go;
      next_s.store_go = 1'b0;
      next_s.fetch_go = 1'b0;
      next_s.wstate = eeac_pkg::EEAC_WR_IDLE;
      next_s.row_erase_act = 1'b0;
      next_s.store_en = 1'b0;
      next_s.unlock = eeac_pkg::EEAC_UNL_IDLE;
      next_s.data = 8'h00;
      next_s.addr_lo = 8'h00;
      next_s.addr_hi = '0;
      next_s.prog_sel = s.prog_sel;
      next_s.row_erase = s.row_erase;
      arr_we = 1'b0;
    end
  end

  // Power-on reset clears every state flop, store enable included; the array cells are not reset.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= `EEAC_RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops.
  assign pready_out = s.pready;
  assign prdata_out = s.prdata;
  assign pslverr_out = s.pslverr;
  assign eeprom_done_flag_out = s.done;
  assign write_busy_out = s.store_go;
  assign flash_row_erase_out = s.row_erase_act;

  // Helper for the write-length check: cycles spent with store go high.
  logic [TW-1:0] busy_cnt;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= s.store_go ? busy_cnt + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  logic wr_ctrl;
  assign wr_ctrl = acc_wr && !warm && sel == eeac_pkg::EEAC_REG_CTRL;

  sequence s_fetch_req;
    wr_ctrl && wbyte[`EEAC_CTRL_FETCH_GO] && !s.prog_sel && !s.store_go;
  endsequence
  sequence s_fetch_done;
    s.fetch_go ##1 (!s.fetch_go && s.data == (s.cfg_sel ? 8'h00 : $past(arr_rdata)));
  endsequence

  property p_fetch_flow;
    s_fetch_req |=> s_fetch_done;
  endproperty
  a_fetch_flow: assert property (p_fetch_flow) else $error("Fetch not done in one cycle.");
  property p_fetch_blocked;
    wr_ctrl && s.prog_sel && !s.fetch_go |=> !s.fetch_go;
  endproperty
  a_fetch_blocked: assert property (p_fetch_blocked) else $error("Fetch set in flash mode.");
  property p_unlock_zero;
    setup && !pwrite_in && sel == eeac_pkg::EEAC_REG_UNLOCK |=> pready_out && prdata_out == 0;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("Unlock register read nonzero.");
  property p_read_zero_bits;
    setup && !pwrite_in && sel == eeac_pkg::EEAC_REG_ADDR_HI |=> prdata_out[31:2] == 0;
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits) else $error("High address bits nonzero.");
  property p_ctrl_bit5;
    setup && !pwrite_in && sel == eeac_pkg::EEAC_REG_CTRL |=> prdata_out[5] == 1'b0;
  endproperty
  a_ctrl_bit5: assert property (p_ctrl_bit5) else $error("Control bit 5 reads one.");
  property p_store_gate;
    $rose(s.store_go) |-> $past(s.store_en) && $past(s.unlock) == eeac_pkg::EEAC_UNL_ARMED;
  endproperty
  a_store_gate: assert property (p_store_gate) else $error("Write started without gate.");
  property p_write_length;
    $fell(s.store_go) && !$past(warm) |-> $past(busy_cnt) == TW'(WRITE_CYCLES - 1) && s.done;
  endproperty
  a_write_length: assert property (p_write_length) else $error("Write length or done wrong.");
  property p_done_sw_clear;
    $fell(s.done) |-> $past(acc_wr && sel == eeac_pkg::EEAC_REG_FLAG);
  endproperty
  a_done_sw_clear: assert property (p_done_sw_clear) else $error("Done flag cleared by hw.");
  property p_abort;
    warm && s.store_go |=> s.abort && !s.store_go && s.data == 8'h00 && s.addr_lo == 8'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("Reset during write not flagged.");
  property p_trace_kept;
    warm |=> s.prog_sel == $past(s.prog_sel) && s.row_erase == $past(s.row_erase);
  endproperty
  a_trace_kept: assert property (p_trace_kept) else $error("Selects lost on warm reset.");
  property p_busy_lock;
    s.store_go && !warm && !s.fetch_go |=> s.data == $past(s.data) && s.addr_lo == $past(s.addr_lo);
  endproperty
  a_busy_lock: assert property (p_busy_lock) else $error("Registers changed during write.");

  // The cell must really read as erased once the erase phase ends, before programming.
  property p_erase_first;
    s.wstate == eeac_pkg::EEAC_WR_ERASE && s.timer == '0 && eeprom_target && !warm
      |=> arr_rdata == `EEAC_ERASED;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("Cell not erased before program.");
  property p_row_erase_end;
    $fell(flash_row_erase_out) && !$past(warm) |-> !s.row_erase && s.done;
  endproperty
  a_row_erase_end: assert property (p_row_erase_end) else $error("Row erase enable kept.");

endmodule

// file: verification/eeac_top_bench.sv
// Self-checking bench for the EEPROM access controller, driven over APB.
`timescale 1ns/100ps
`include "eeac_map.svh"
module eeac_top_bench;
  // A short write time keeps the run brief; the write-length check below compares against it.
  localparam int WCYC = 16;
  localparam logic [11:0] CT = `EEAC_IDX_CTRL;
  localparam logic [11:0] UL = `EEAC_IDX_UNLOCK;
  localparam logic [11:0] DT = `EEAC_IDX_DATA;
  localparam logic [11:0] AL = `EEAC_IDX_ADDR_LO;
  localparam logic [11:0] AH = `EEAC_IDX_ADDR_HI;
  localparam logic [11:0] FL = `EEAC_IDX_FLAG;
  logic clk_sys_in;
  logic rstn_in;
  logic master_clear_reset;
  logic wdt;
  logic psel;
  logic penable;
  logic pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic done;
  logic busy;
  logic row_er;
  logic [31:0] rdv;
  logic errv;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  eeac_top #(.WRITE_CYCLES(WCYC)) u_eeac_top (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .master_clear_reset_in(master_clear_reset),
    .watchdog_timer_reset_in(wdt),
    .paddr_in(paddr),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .pwdata_in(pwdata),
    .pstrb_in(pstrb),
    .pready_out(pready),
    .prdata_out(prdata),
    .pslverr_out(pslverr),
    .eeprom_done_flag_out(done),
    .write_busy_out(busy),
    .flash_row_erase_out(row_er)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // A hang is cut short here so that the verdict is still printed.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED timeout expected 0 seen 1");
      end_of_test();
    end
  end

  task end_of_test;
    $display("counts: errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; it waits an edge first so that no signal is assigned twice at one edge.
  task apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    // Only the bench timeout ends this wait; the slave decides how long it takes.
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task rd(input logic [11:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    check(what, {24'h0, exp}, rdv);
  endtask

  // Unlock keys followed by the control write that carries the go bit.
  task start(input logic [7:0] v);
    wr(UL, `EEAC_KEY_FIRST);
    wr(UL, `EEAC_KEY_SECOND);
    wr(CT, v);
  endtask

  // Counts the cycles for which the write stays busy, then looks at the done flag.
  task wait_busy;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      if (busy === 1'b1) n++;
    end while (busy === 1'b1 && n < 1000);
    check("done at end", 32'h1, {31'h0, done});
  endtask

  // Main sequence.
  initial begin
    rstn_in = 1'b0;
    master_clear_reset = 1'b0;
    wdt = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(CT, 8'h00, "ctrl reset");
    rd(DT, 8'h00, "data reset");
    rd(AL, 8'h00, "addr low reset");
    rd(AH, 8'h00, "addr high reset");
    rd(FL, 8'h00, "flag reset");
    apb(1'b0, 12'h000, 8'h00);
    check("unmapped error", 32'h1, {31'h0, errv});
    check("unmapped data", 32'h0, rdv);
    wr(AH, 8'hFF);
    rd(AH, 8'h03, "addr high bits");
    wr(UL, 8'h5A);
    rd(UL, 8'h00, "unlock reads zero");
    wr(CT, 8'h20);
    rd(CT, 8'h00, "ctrl bit 5");
    // Go and enable in one write must not start a write.
    start(8'h06);
    // The write lands at the edge that ends the access, so look half a cycle later.
    @(negedge clk_sys_in);
    check("busy same write", 32'h0, {31'h0, busy});
    rd(CT, 8'h04, "ctrl after refused go");
    // Keys in the wrong order leave the controller locked.
    wr(UL, `EEAC_KEY_SECOND);
    wr(UL, `EEAC_KEY_FIRST);
    wr(CT, 8'h06);
    @(negedge clk_sys_in);
    check("busy bad keys", 32'h0, {31'h0, busy});
    wr(AL, 8'hFF);
    wr(DT, 8'h5A);
    start(8'h06);
    @(negedge clk_sys_in);
    check("busy started", 32'h1, {31'h0, busy});
    // Edits during the write must bounce off, and go cannot be cleared.
    wr(DT, 8'h00);
    wr(AL, 8'h00);
    wr(CT, 8'h04);
    rd(CT, 8'h06, "ctrl while busy");
    wait_busy();
    rd(DT, 8'h5A, "data kept");
    rd(AL, 8'hFF, "addr kept");
    rd(FL, 8'h10, "done set");
    wr(FL, 8'h00);
    rd(FL, 8'h00, "done cleared");
    wr(AH, 8'h00);
    wr(AL, 8'h00);
    wr(DT, 8'hC3);
    start(8'h06);
    wait_busy();
    check("write length", WCYC, n);
    rd(CT, 8'h04, "go cleared");
    // Fetch both ends of the array.
    wr(DT, 8'h00);
    wr(AH, 8'h03);
    wr(AL, 8'hFF);
    wr(CT, 8'h05);
    rd(DT, 8'h5A, "fetch top");
    rd(CT, 8'h04, "fetch go cleared");
    rd(DT, 8'h5A, "data holds");
    wr(AH, 8'h00);
    wr(AL, 8'h00);
    wr(CT, 8'h05);
    rd(DT, 8'hC3, "fetch bottom");
    wr(DT, 8'h11);
    wr(CT, 8'h84);
    wr(CT, 8'h85);
    rd(DT, 8'h11, "fetch blocked");
    rd(CT, 8'h84, "program select");
    wr(CT, 8'h44);
    wr(CT, 8'h45);
    rd(DT, 8'h00, "config fetch");
    // Row erase runs to completion and then drops its enable.
    wr(CT, 8'h94);
    start(8'h96);
    @(posedge clk_sys_in);
    check("row erase out", 32'h1, {31'h0, row_er});
    wait_busy();
    rd(CT, 8'h84, "row erase cleared");
    // Warm resets mid-write: watchdog first, then master clear with its sync delay.
    for (int k = 0; k < 2; k++) begin
      wr(CT, k ? 8'h94 : 8'h04);
      wr(AL, 8'h07);
      wr(DT, 8'h3C);
      start(k ? 8'h96 : 8'h06);
      @(posedge clk_sys_in);
      if (k == 0) begin
        wdt <= 1'b1;
        @(posedge clk_sys_in);
        wdt <= 1'b0;
      end else begin
        master_clear_reset <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        master_clear_reset <= 1'b0;
      end
      repeat (3) @(posedge clk_sys_in);
      check("busy after warm reset", 32'h0, {31'h0, busy});
      rd(CT, k ? 8'h98 : 8'h08, "abort flag");
      rd(DT, 8'h00, "data zeroed");
      rd(AL, 8'h00, "addr zeroed");
      rd(FL, 8'h10, "done kept");
      wr(CT, 8'h00);
      rd(CT, 8'h00, "abort cleared");
    end
    end_of_test();
  end
endmodule
